// File: rtl/spc_defs.svh
// Constants of the strap and pixel configuration register bank
// Assumes inclusion by bare name from rtl/
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// ==========================================================================
// Host I/O ports and extended indices
`define SPC_IO_INDEX      16'h03D6
`define SPC_IO_DATA       16'h03D7
`define SPC_IDX_HOSTCFG   8'h08
`define SPC_IDX_STRAP_LO  8'h70
`define SPC_IDX_STRAP_HI  8'h71
`define SPC_IDX_PIXCFG0   8'h80
`define SPC_IDX_MCLKDIV   8'hCF

// ==========================================================================
// Reset values and masks
`define SPC_IDX_RST       8'h00
`define SPC_PIXCFG0_RST   8'h00
`define SPC_PIXCFG0_RMASK 8'hAF
`define SPC_MCLKDIV_RST   8'h00
`define SPC_UNMAPPED_RD   8'h00

// ==========================================================================
// Field positions
`define SPC_B_DAC8        7
`define SPC_B_AVG         5
`define SPC_B_EXTST       3
`define SPC_B_FPOVS       2
`define SPC_B_CRTOVS      1
`define SPC_B_PALSEL      0
`define SPC_S_CLKTEST     7
`define SPC_S_TRI         6
`define SPC_S_CLKSRC      4
`define SPC_S_LEGIO       1
`define SPC_S_ONE         0
`define SPC_B_MCLK_SRC    2
`define SPC_B_DOT_CLOCK_SRC    1
`define SPC_B_HOST_LEGIO  1
`define SPC_PANEL_LSB     3

// ==========================================================================
// Timing
`define SPC_STRAP_HOLD    3

`endif

// File: rtl/spc_pkg.sv
// Types shared by the strap and pixel configuration bank
// Assumes spc_defs.svh alongside
package spc_pkg;
  typedef enum logic [1:0] {CAP_RESET, CAP_HOLD, CAP_DONE} spc_cap_state_t;
  typedef enum logic [1:0] {PAL_MASK, PAL_WX, PAL_STATE, PAL_OTHER} spc_pal_reg_t;
endpackage

// File: rtl/spc_strap_latch.sv
// Strap pin synchroniser and capture window
// Assumes clk_sys runs during reset so the synchroniser sees the pins
`timescale 1ns/100ps
`include "spc_defs.svh"
module spc_strap_latch
  import spc_pkg::*;
#(
  parameter int W    = 18,
  parameter int HOLD = `SPC_STRAP_HOLD
)(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] straps,
  output logic              released,
  output logic              done_pulse
);
  // ========================================================================
  // Elaboration check
  if (HOLD < 3 || HOLD > 255) begin : g_chk
    $error("HOLD must cover the synchroniser, 3..255");
  end

  logic [W-1:0]   sync1_r;
  logic [W-1:0]   sync2_r;
  logic [W-1:0]   straps_r;
  logic [7:0]     cnt_r;
  spc_cap_state_t state_r;

  // ========================================================================
  // No reset here: the synchroniser must keep sampling while the chip is held in reset
  always_ff @(posedge clk_sys) begin
    sync1_r <= pin_in;
    sync2_r <= sync1_r;
    if (state_r == CAP_HOLD) begin
      straps_r <= sync2_r;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= CAP_RESET;
      cnt_r   <= 8'h00;
    end else begin
      unique case (state_r)
        CAP_RESET: state_r <= CAP_HOLD;
        CAP_HOLD: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(HOLD - 1)) begin
            state_r <= CAP_DONE;
          end
        end
        CAP_DONE: state_r <= CAP_DONE;
      endcase
    end
  end

  assign straps     = straps_r;
  assign released   = (state_r == CAP_DONE);
  assign done_pulse = (state_r == CAP_HOLD) && (cnt_r == 8'(HOLD - 1));
endmodule // spc_strap_latch

// File: rtl/spc_index_port.sv
// Index/data port decoder of the extended register space
// Assumes one-cycle host I/O strobes on clk_sys
`timescale 1ns/100ps
`include "spc_defs.svh"
module spc_index_port
  import spc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        decode_en,
  output logic      [7:0]  index,
  output logic             data_wr,
  output logic             data_rd,
  output logic             index_rd
);
  // ========================================================================
  // Decode
  function automatic logic port_hit(input logic [15:0] a, input logic [15:0] p, input logic en);
    port_hit = en && (a == p);
  endfunction

  logic [7:0] index_r;
  wire        idx_hit  = port_hit(io_addr, `SPC_IO_INDEX, decode_en);
  wire        data_hit = port_hit(io_addr, `SPC_IO_DATA, decode_en);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      index_r <= `SPC_IDX_RST;
    end else if (idx_hit && io_wr) begin
      index_r <= io_wdata;
    end
  end

  assign index    = index_r;
  assign data_wr  = data_hit && io_wr;
  assign data_rd  = data_hit && io_rd;
  assign index_rd = idx_hit && io_rd;
endmodule // spc_index_port

// File: rtl/spc_top.sv
// Strap latch and pixel pipeline configuration register bank
// Assumes host I/O strobes synchronous to clk_sys, pins pass through here
//
// Function
// - Pins undriven in reset, levels captured
// - Index 70h reads address straps 7..1
// - Low addr 7 strap enables clock test
// - Low addr 6 strap floats two outputs
// - Low addr 4 strap selects external clocks
// - Clock source bits reset from addr 4
// - Addr 1 strap gates legacy I/O decode
// - Strap low bit 0 reads one
// - Straps 5, 3, 2 readback only
// - Index 71h reads data/address straps
// - Data straps 6..3 form panel code
// - Pixel register index 80h, resets zero
// - Bit 7 selects 8-bit converters
// - Bit 5 averages stretched panel pixels
// - Bit 3 swaps three palette reads
// - Bit 2 enables panel overscan colour
// - Bit 1 enables CRT overscan colour
// - Bit 0 steers palette sub-addressing
// - Reserved bits 6, 4 read zero
`timescale 1ns/100ps
`include "spc_defs.svh"
module spc_top
  import spc_pkg::*;
#(
  parameter int STRAP_HOLD = `SPC_STRAP_HOLD
)(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Host I/O
  input  wire logic [15:0]  io_addr,
  input  wire logic         io_wr,
  input  wire logic         io_rd,
  input  wire logic [7:0]   io_wdata,
  output logic      [7:0]   io_rdata,
  output logic              io_rvalid,
  // Memory bus pins
  input  wire logic [9:0]   mem_addr_in,
  output logic      [9:0]   mem_addr_out,
  output logic              mem_addr_oe,
  input  wire logic [7:0]   mem_data_in,
  output logic      [7:0]   mem_data_out,
  output logic              mem_data_oe,
  input  wire logic [9:0]   mc_addr,
  input  wire logic         mc_addr_oe,
  input  wire logic [7:0]   mc_data,
  input  wire logic         mc_data_oe,
  // Clock test and clock source
  input  wire logic         mclk_synth,
  input  wire logic         video_clock_synth,
  input  wire logic         rom_select_n_int,
  input  wire logic         port_clk_int,
  output logic              bios_rom_select_n,
  output logic              video_port_clk,
  output logic              clk_test_mode,
  output logic              mclk_src_internal,
  output logic              dot_clock_src_internal,
  // Panel control outputs
  input  wire logic         activity_int,
  input  wire logic         backlight_int,
  output logic              activity_indicator,
  output logic              activity_indicator_oe,
  output logic              backlight_enable,
  output logic              backlight_enable_oe,
  // Status to other logic
  output logic              legacy_io_en,
  output logic      [3:0]   panel_type,
  output logic              dac_8bit,
  output logic              cursor_pal_sel,
  // Flat panel pixel path
  input  wire logic         fp_pix_valid,
  input  wire logic [23:0]  fp_pix_in,
  input  wire logic         fp_pix_replicated,
  input  wire logic         fp_border,
  input  wire logic         hstretch_active,
  input  wire logic         fp_path_en,
  input  wire logic [23:0]  overscan1_color,
  output logic      [23:0]  fp_pix_out,
  output logic              fp_pix_out_valid,
  // CRT pixel path
  input  wire logic [23:0]  crt_pix_in,
  input  wire logic         crt_border,
  input  wire logic [23:0]  overscan0_color,
  output logic      [23:0]  crt_pix_out,
  // Palette reads
  input  wire logic         pal_rd,
  input  spc_pal_reg_t      pal_rd_sel,
  input  wire logic [7:0]   pal_norm_data,
  input  wire logic [7:0]   hold_red,
  input  wire logic [7:0]   hold_green,
  input  wire logic [5:0]   pal_sm_status,
  output logic      [7:0]   pal_rdata,
  // Palette sub-addressed writes
  input  wire logic         pal_sub_we,
  input  wire logic [7:0]   pal_sub_addr,
  output logic              main_pal_we,
  output logic      [7:0]   main_pal_addr,
  output logic              cursor_pal_we,
  output logic      [2:0]   cursor_pal_addr
);
  // ========================================================================
  // Strap capture
  if (STRAP_HOLD < 3 || STRAP_HOLD > 255) begin : g_chk
    $error("STRAP_HOLD outside 3..255");
  end

  logic [17:0] straps_raw;
  logic        released;
  logic        strap_done;

  spc_strap_latch #(
    .W    (18),
    .HOLD (STRAP_HOLD)
  ) u_strap (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .pin_in     ({mem_data_in, mem_addr_in}),
    .straps     (straps_raw),
    .released   (released),
    .done_pulse (strap_done)
  );

  // Until capture ends the straps read as pulled up
  wire [17:0] straps   = released ? straps_raw : 18'h3FFFF;
  wire [9:0]  s_addr   = straps[9:0];
  wire [7:0]  s_data   = straps[17:10];

  // Memory bus stays undriven until the capture window has closed
  assign mem_addr_out = mc_addr;
  assign mem_data_out = mc_data;

  assign mem_addr_oe  = released && mc_addr_oe;
  assign mem_data_oe  = released && mc_data_oe;

  // ========================================================================
  // Strap driven hardware
  wire clk_test_w = !s_addr[`SPC_S_CLKTEST];
  wire float_w    = !s_addr[`SPC_S_TRI];
  wire legio_w    = s_addr[`SPC_S_LEGIO];

  assign clk_test_mode     = clk_test_w;

  // Clock muxes are plain selects; straps never change after capture
  assign bios_rom_select_n = clk_test_w ? mclk_synth : rom_select_n_int;
  assign video_port_clk    = clk_test_w ? video_clock_synth : port_clk_int;

  // Only the enables float
  assign activity_indicator    = activity_int;
  assign backlight_enable      = backlight_int;
  assign activity_indicator_oe = released && !float_w;
  assign backlight_enable_oe   = released && !float_w;

  // No decode before capture
  assign legacy_io_en = released && legio_w;
  assign panel_type   = s_data[`SPC_PANEL_LSB+3:`SPC_PANEL_LSB];

  // ========================================================================
  // Host index/data port
  logic [7:0] index;
  logic       data_wr;
  logic       data_rd;
  logic       index_rd;

  spc_index_port u_port (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .io_addr   (io_addr),
    .io_wr     (io_wr),
    .io_rd     (io_rd),
    .io_wdata  (io_wdata),
    .decode_en (legacy_io_en),
    .index     (index),
    .data_wr   (data_wr),
    .data_rd   (data_rd),
    .index_rd  (index_rd)
  );

  // ========================================================================
  // Writable registers
  logic [7:0] pixcfg_r;
  logic [7:0] mclkdiv_r;

  wire wr_pixcfg  = data_wr && (index == `SPC_IDX_PIXCFG0);
  wire wr_mclkdiv = data_wr && (index == `SPC_IDX_MCLKDIV);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pixcfg_r <= `SPC_PIXCFG0_RST;
    end else if (wr_pixcfg) begin
      pixcfg_r <= io_wdata & `SPC_PIXCFG0_RMASK;
    end
  end

  // Strap load happens before any host access can decode
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mclkdiv_r <= `SPC_MCLKDIV_RST;
    end else if (strap_done) begin
      mclkdiv_r[`SPC_B_MCLK_SRC] <= straps_raw[`SPC_S_CLKSRC];
      mclkdiv_r[`SPC_B_DOT_CLOCK_SRC] <= straps_raw[`SPC_S_CLKSRC];
    end else if (wr_mclkdiv) begin
      mclkdiv_r <= io_wdata;
    end
  end

  // 1 selects internal clocks
  assign mclk_src_internal = mclkdiv_r[`SPC_B_MCLK_SRC];
  assign dot_clock_src_internal = mclkdiv_r[`SPC_B_DOT_CLOCK_SRC];

  // ========================================================================
  // Pixel configuration fields
  wire f_dac8   = pixcfg_r[`SPC_B_DAC8];
  wire f_avg    = pixcfg_r[`SPC_B_AVG];
  wire f_extst  = pixcfg_r[`SPC_B_EXTST];
  wire f_fpovs  = pixcfg_r[`SPC_B_FPOVS];
  wire f_crtovs = pixcfg_r[`SPC_B_CRTOVS];
  wire f_palsel = pixcfg_r[`SPC_B_PALSEL];

  assign dac_8bit       = f_dac8;
  assign cursor_pal_sel = f_palsel;

  // ========================================================================
  // Register readback
  wire [7:0] strap_lo_w  = {s_addr[7:1], 1'b1};
  wire [7:0] strap_hi_w  = {s_data[7:2], s_addr[9:8]};

  // Only the decode strap kept
  wire [7:0] hostcfg_w   = {6'h00, legio_w, 1'b0};
  wire [7:0] rd_mux      = (index == `SPC_IDX_STRAP_LO) ? strap_lo_w :
                           (index == `SPC_IDX_STRAP_HI) ? strap_hi_w :
                           (index == `SPC_IDX_PIXCFG0)  ? pixcfg_r   :
                           (index == `SPC_IDX_MCLKDIV)  ? mclkdiv_r  :
                           (index == `SPC_IDX_HOSTCFG)  ? hostcfg_w  :
                           `SPC_UNMAPPED_RD;

  // Index port reads the index
  wire [7:0] rd_sel      = index_rd ? index : rd_mux;

  logic [7:0] rdata_r;
  logic       rvalid_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= data_rd || index_rd;
      if (data_rd || index_rd) begin
        rdata_r <= rd_sel;
      end
    end
  end

  assign io_rdata  = rdata_r;
  assign io_rvalid = rvalid_r;

  // ========================================================================
  // Flat panel pixel averaging
  // One pixel of latency: a replicated pixel needs its successor first
  logic [23:0] fp_hold_r;
  logic        fp_rep_r;
  logic [23:0] fp_out_r;
  logic        fp_out_valid_r;
  logic [23:0] avg_w;

  wire        avg_on    = f_avg && hstretch_active && fp_path_en;
  wire [23:0] fp_src    = (fp_border && f_fpovs) ? overscan1_color : fp_pix_in;

  // Floor of the mean
  for (genvar c = 0; c < 3; c++) begin : g_avg
    wire [8:0] sum = {1'b0, fp_hold_r[c*8 +: 8]} + {1'b0, fp_src[c*8 +: 8]};
    assign avg_w[c*8 +: 8] = sum[8:1];
  end

  wire [23:0] fp_next = (avg_on && fp_rep_r) ? avg_w : fp_hold_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fp_hold_r      <= 24'h000000;
      fp_rep_r       <= 1'b0;
      fp_out_r       <= 24'h000000;
      fp_out_valid_r <= 1'b0;
    end else begin
      fp_out_valid_r <= fp_pix_valid;
      if (fp_pix_valid) begin
        fp_out_r  <= fp_next;
        fp_hold_r <= fp_src;
        fp_rep_r  <= fp_pix_replicated;
      end
    end
  end

  assign fp_pix_out       = fp_out_r;
  assign fp_pix_out_valid = fp_out_valid_r;

  // ========================================================================
  // CRT border colour, never averaged
  logic [23:0] crt_out_r;
  wire  [23:0] crt_next = (crt_border && f_crtovs) ? overscan0_color : crt_pix_in;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      crt_out_r <= 24'h000000;
    end else begin
      crt_out_r <= crt_next;
    end
  end

  assign crt_pix_out = crt_out_r;

  // ========================================================================
  // Palette reads with extended status
  // Normal palette traffic relies on software having cleared the status mode
  logic [7:0] pal_rdata_r;
  wire  [7:0] pal_ext = (pal_rd_sel == PAL_MASK)  ? hold_red :
                        (pal_rd_sel == PAL_WX)    ? hold_green :
                        (pal_rd_sel == PAL_STATE) ? {pal_sm_status, 2'b00} :
                        pal_norm_data;

  wire  [7:0] pal_sel = f_extst ? pal_ext : pal_norm_data;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pal_rdata_r <= 8'h00;
    end else if (pal_rd) begin
      pal_rdata_r <= pal_sel;
    end
  end

  assign pal_rdata = pal_rdata_r;

  // ========================================================================
  // Palette sub-address steering
  // Same cycle, unbuffered
  assign main_pal_we     = pal_sub_we && !f_palsel;
  assign cursor_pal_we   = pal_sub_we && f_palsel;

  assign main_pal_addr   = pal_sub_addr;
  assign cursor_pal_addr = pal_sub_addr[2:0];
endmodule // spc_top

// File: verification/spc_strap_model.sv
// Strap resistors on the memory bus pins
// Assumes the controller's pin enables are high while it drives
`timescale 1ns/100ps
module spc_strap_model (
  input  wire logic [9:0] strap_addr,
  input  wire logic [7:0] strap_data,
  input  wire logic [9:0] mem_addr_out,
  input  wire logic       mem_addr_oe,
  input  wire logic [7:0] mem_data_out,
  input  wire logic       mem_data_oe,
  output logic      [9:0] mem_addr_in,
  output logic      [7:0] mem_data_in
);
  // ==========================================================================
  // Pin levels
  // Resistors win only while the controller floats the bus
  assign mem_addr_in = mem_addr_oe ? mem_addr_out : strap_addr;
  assign mem_data_in = mem_data_oe ? mem_data_out : strap_data;
endmodule // spc_strap_model

// File: verification/spc_top_monitor.sv
// Port checker of the strap and pixel configuration bank
// Assumes binding onto spc_top, single clock domain
`timescale 1ns/100ps
`include "spc_defs.svh"
module spc_top_monitor
  import spc_pkg::*;
#(
  parameter int STRAP_HOLD = `SPC_STRAP_HOLD
)(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic        mem_addr_oe,
  input wire logic        mem_data_oe,
  input wire logic        bios_rom_select_n,
  input wire logic        clk_test_mode,
  input wire logic        mclk_synth,
  input wire logic        rom_select_n_int,
  input wire logic        activity_indicator,
  input wire logic        activity_indicator_oe,
  input wire logic        backlight_enable_oe,
  input wire logic        activity_int,
  input wire logic        legacy_io_en,
  input wire logic [3:0]  panel_type,
  input wire logic        dac_8bit,
  input wire logic        cursor_pal_sel,
  input wire logic        fp_pix_valid,
  input wire logic        fp_pix_out_valid,
  input wire logic        pal_rd,
  input spc_pal_reg_t     pal_rd_sel,
  input wire logic [7:0]  pal_norm_data,
  input wire logic [7:0]  pal_rdata,
  input wire logic        pal_sub_we,
  input wire logic        main_pal_we,
  input wire logic        cursor_pal_we
);
  // ==========================================================================
  // Index tracking
  logic [7:0] idx_r;
  wire logic  dec = legacy_io_en && (io_addr == `SPC_IO_INDEX || io_addr == `SPC_IO_DATA);
  wire logic  dat = dec && io_addr == `SPC_IO_DATA;
  wire logic  wd7 = io_wdata[7];
  wire logic  wd0 = io_wdata[0];
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst) idx_r <= 8'h00;
    else if (io_wr && dec && !dat) idx_r <= io_wdata;

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_float; $rose(nrst) |-> (!mem_addr_oe && !mem_data_oe) [*3]; endproperty
  property p_tmux; bios_rom_select_n == (clk_test_mode ? mclk_synth : rom_select_n_int); endproperty
  property p_pairoe; activity_indicator_oe == backlight_enable_oe && activity_indicator == activity_int; endproperty
  property p_ans; io_rd && dec |=> io_rvalid; endproperty
  property p_ref; !(io_rd && dec) |=> !io_rvalid; endproperty
  property p_one; io_rd && dat && idx_r == 8'h70 |=> io_rdata[0]; endproperty
  property p_rsv; io_rd && dat && idx_r == 8'h80 |=> !io_rdata[6] && !io_rdata[4]; endproperty
  property p_wr80; io_wr && dat && idx_r == 8'h80 |=> dac_8bit == $past(wd7) && cursor_pal_sel == $past(wd0);
  endproperty
  property p_sub; pal_sub_we |-> main_pal_we == !cursor_pal_sel && cursor_pal_we == cursor_pal_sel; endproperty
  property p_pal; pal_rd && pal_rd_sel == PAL_OTHER |=> pal_rdata == $past(pal_norm_data); endproperty
  property p_fpv; fp_pix_valid |=> fp_pix_out_valid; endproperty
  property p_keep; legacy_io_en |=> $stable(panel_type) && $stable(clk_test_mode); endproperty
  a_float: assert property (p_float) else $error("pins driven in capture");
  a_tmux: assert property (p_tmux) else $error("rom select mux wrong");
  a_pairoe: assert property (p_pairoe) else $error("panel outputs wrong");
  a_ans: assert property (p_ans) else $error("read not answered");
  a_ref: assert property (p_ref) else $error("stray read answer");
  a_one: assert property (p_one) else $error("strap bit 0 low");
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  a_wr80: assert property (p_wr80) else $error("pixel config write lost");
  a_sub: assert property (p_sub) else $error("palette steering wrong");
  a_pal: assert property (p_pal) else $error("palette read wrong");
  a_fpv: assert property (p_fpv) else $error("pixel valid lost");
  a_keep: assert property (p_keep) else $error("straps changed");
  c_rd: cover property (io_rvalid);
  c_tst: cover property (clk_test_mode);
  c_pix: cover property (fp_pix_out_valid && fp_pix_valid);
  c_cur: cover property (cursor_pal_we);
endmodule // spc_top_monitor

bind spc_top spc_top_monitor #(.STRAP_HOLD(STRAP_HOLD)) u_mon (.*);

// File: verification/spc_top_bench.sv
// Bench of the strap and pixel configuration bank
// Assumes spc_top, the strap model and the bound checker
`timescale 1ns/100ps
`include "spc_defs.svh"
module spc_top_bench;
  import spc_pkg::*;
  localparam int SH = 3;
  logic         clk_sys, nrst, io_wr, io_rd, io_rvalid, mem_addr_oe, mem_data_oe, mc_addr_oe, mc_data_oe;
  logic         mclk_synth, video_clock_synth, rom_select_n_int, port_clk_int, bios_rom_select_n, video_port_clk;
  logic         clk_test_mode, mclk_src_internal, dot_clock_src_internal, activity_int, backlight_int;
  logic         activity_indicator, activity_indicator_oe, backlight_enable, backlight_enable_oe;
  logic         legacy_io_en, dac_8bit, cursor_pal_sel, fp_pix_valid, fp_pix_replicated, fp_border;
  logic         hstretch_active, fp_path_en, fp_pix_out_valid, crt_border, pal_rd, pal_sub_we;
  logic         main_pal_we, cursor_pal_we;
  logic [15:0]  io_addr;
  logic [15:0]  cnt = 16'h0000;
  logic [7:0]   io_wdata, io_rdata, mem_data_in, mem_data_out, mc_data, strap_data, pal_norm_data;
  logic [7:0]   hold_red, hold_green, pal_rdata, pal_sub_addr, main_pal_addr;
  logic [9:0]   mem_addr_in, mem_addr_out, mc_addr, strap_addr;
  logic [23:0]  fp_pix_in, overscan1_color, fp_pix_out, crt_pix_in, overscan0_color, crt_pix_out;
  logic [5:0]   pal_sm_status;
  logic [3:0]   panel_type;
  logic [2:0]   cursor_pal_addr;
  spc_pal_reg_t pal_rd_sel;
  int           fails, checked;

  // ==========================================================================
  // Design, strap resistors, free-running activity
  spc_top #(.STRAP_HOLD(SH)) DUT (.*);
  spc_strap_model u_straps (.*);
  // Counter keeps the muxed and pass-through inputs moving
  assign {backlight_int, activity_int, port_clk_int, rom_select_n_int, video_clock_synth, mclk_synth} = cnt[5:0];
  assign mc_addr = cnt[9:0];
  assign mc_data = cnt[15:8];
  assign crt_pix_in = {cnt, cnt[7:0]};
  always @(posedge clk_sys) cnt <= cnt + 16'h0001;
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Shared tasks
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task rst(input logic [9:0] a, input logic [7:0] d);
    nrst <= 1'b0;
    strap_addr <= a;
    strap_data <= d;
    repeat (2) @(posedge clk_sys);
    #1 chk({mem_addr_oe, mem_data_oe, activity_indicator_oe}, 3'h0);
    @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (SH + 2) @(posedge clk_sys);
    #1;
  endtask
  task io(input logic [15:0] a, input logic [7:0] d, input logic r);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= !r;
    io_rd <= r;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    io(`SPC_IO_INDEX, i, 1'b0);
    io(`SPC_IO_DATA, d, 1'b0);
  endtask
  // Answer latency is fixed at one cycle, so no wait loop
  task rd(input logic [7:0] i, input logic v, input logic [7:0] e);
    io(`SPC_IO_INDEX, i, 1'b0);
    io(`SPC_IO_DATA, 8'h00, 1'b1);
    #1 chk(io_rvalid, v);
    if (v) chk(io_rdata, e);
  endtask
  task px(input logic [23:0] p, input logic rep, input logic b);
    @(posedge clk_sys);
    fp_pix_valid <= 1'b1;
    fp_pix_in <= p;
    fp_pix_replicated <= rep;
    fp_border <= b;
    crt_border <= b;
  endtask
  task idle;
    @(posedge clk_sys);
    fp_pix_valid <= 1'b0;
    #1;
  endtask
  task pr(input spc_pal_reg_t s, input logic [7:0] e);
    @(posedge clk_sys);
    pal_rd <= 1'b1;
    pal_rd_sel <= s;
    @(posedge clk_sys);
    pal_rd <= 1'b0;
    #1 chk(pal_rdata, e);
  endtask

  // ==========================================================================
  // Scenarios
  task t_regs;
    chk({clk_test_mode, bios_rom_select_n, video_port_clk}, {1'b0, rom_select_n_int, port_clk_int});
    chk({activity_indicator_oe, backlight_enable_oe}, 2'h3);
    chk({mclk_src_internal, dot_clock_src_internal, legacy_io_en}, 3'h7);
    chk(panel_type, 4'h6);
    chk({backlight_enable, mem_addr_oe, mem_data_oe, mem_addr_out, mem_data_out}, {backlight_int, 2'h3, mc_addr, mc_data});
    rd(`SPC_IDX_STRAP_LO, 1'b1, 8'hD7);
    rd(`SPC_IDX_STRAP_HI, 1'b1, 8'hB6);
    rd(`SPC_IDX_HOSTCFG, 1'b1, 8'h02);
    wr(`SPC_IDX_STRAP_LO, 8'h00);
    rd(`SPC_IDX_STRAP_LO, 1'b1, 8'hD7);
    rd(8'h55, 1'b1, 8'h00);
    io(`SPC_IO_INDEX, 8'h00, 1'b1);
    #1 chk(io_rdata, 8'h55);
    rd(`SPC_IDX_PIXCFG0, 1'b1, 8'h00);
    wr(`SPC_IDX_PIXCFG0, 8'hFF);
    rd(`SPC_IDX_PIXCFG0, 1'b1, 8'hAF);
    chk({dac_8bit, cursor_pal_sel}, 2'h3);
    wr(`SPC_IDX_MCLKDIV, 8'h02);
    #1 chk({mclk_src_internal, dot_clock_src_internal}, 2'h1);
  endtask
  task t_pixel;
    wr(`SPC_IDX_PIXCFG0, 8'h20);
    #1 chk(dac_8bit, 1'b0);
    px(24'h204060, 1'b1, 1'b0);
    px(24'h40A081, 1'b0, 1'b0);
    idle;
    chk({fp_pix_out_valid, fp_pix_out}, {1'b1, 24'h307070});
    wr(`SPC_IDX_PIXCFG0, 8'h06);
    px(24'h204060, 1'b1, 1'b1);
    px(24'h40A081, 1'b0, 1'b0);
    #1 chk(crt_pix_out, overscan0_color);
    idle;
    chk(fp_pix_out, overscan1_color);
  endtask
  task t_palette;
    wr(`SPC_IDX_PIXCFG0, 8'h08);
    pr(PAL_MASK, hold_red);
    pr(PAL_WX, hold_green);
    pr(PAL_STATE, {pal_sm_status, 2'h0});
    pr(PAL_OTHER, pal_norm_data);
    wr(`SPC_IDX_PIXCFG0, 8'h00);
    pr(PAL_MASK, pal_norm_data);
    @(posedge clk_sys);
    pal_sub_we <= 1'b1;
    #1 chk({main_pal_we, cursor_pal_we, main_pal_addr}, {2'h2, pal_sub_addr});
    wr(`SPC_IDX_PIXCFG0, 8'h01);
    #1 chk({main_pal_we, cursor_pal_we, cursor_pal_addr}, 5'h0D);
  endtask
  task t_no_io;
    @(posedge clk_sys);
    rst(10'h12C, 8'h48);
    chk({clk_test_mode, bios_rom_select_n, video_port_clk}, {1'b1, mclk_synth, video_clock_synth});
    chk({activity_indicator_oe, backlight_enable_oe}, 2'h0);
    chk({mclk_src_internal, dot_clock_src_internal}, 2'h0);
    chk({legacy_io_en, panel_type, dac_8bit, cursor_pal_sel}, 7'h24);
    rd(`SPC_IDX_STRAP_LO, 1'b0, 8'h00);
  endtask

  initial begin
    {nrst, io_wr, io_rd, io_addr, io_wdata, fp_pix_valid, fp_pix_replicated, fp_border, crt_border} = '0;
    {pal_rd, pal_sub_we, fp_pix_in} = '0;
    {mc_addr_oe, mc_data_oe, hstretch_active, fp_path_en} = 4'hF;
    {hold_red, hold_green, pal_norm_data, pal_sub_addr} = 32'h3CC35AA5;
    {overscan0_color, overscan1_color} = 48'hA1B2C3123456;
    pal_sm_status = 6'h2D;
    pal_rd_sel = PAL_OTHER;
    fails = 0;
    checked = 0;
    rst(10'h2D6, 8'hB4);
    t_regs;
    t_pixel;
    t_palette;
    t_no_io;
    report_and_stop;
  end
endmodule // spc_top_bench
